// ===== rac_pkg.sv
package rac_pkg;
  // ----------------------------------------------------------------
  // Widths and byte counts
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int RAMP_W = 88;
  localparam logic [3:0] WORD_BYTES = 4'h4;
  localparam logic [3:0] RAMP_BYTES = 4'hb;

  // ----------------------------------------------------------------
  // Auxiliary register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_INIT_A = 5'h00;
  localparam logic [4:0] IDX_INIT_B = 5'h01;
  localparam logic [4:0] IDX_INIT_C = 5'h02;
  localparam logic [4:0] IDX_INIT_D = 5'h03;
  localparam logic [4:0] IDX_TX_LEVEL = 5'h04;
  localparam logic [4:0] IDX_SIG_CFG = 5'h05;
  localparam logic [4:0] IDX_BANK = 5'h07;
  localparam logic [4:0] IDX_PART = 5'h08;
  localparam logic [4:0] IDX_EXTRA = 5'h0c;
  localparam logic [4:0] IDX_EXT_OPT = 5'h0d;
  localparam logic [4:0] IDX_RAMP = 5'h0e;

  // ----------------------------------------------------------------
  // Reset and initialization values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] RST_INIT_D = 32'h0300_1200;
  localparam logic [31:0] VAL_INIT_A = 32'h404b_01e2;
  localparam logic [31:0] VAL_INIT_B = 32'hc04b_0000;
  localparam logic [31:0] VAL_INIT_C = 32'hd0fc_8c02;
  localparam logic [31:0] VAL_INIT_D = 32'h9900_3941;
  localparam logic [31:0] VAL_TX_HIGH = 32'hd99e_860b;
  localparam logic [31:0] VAL_TX_CARRIER = 32'hd99e_8621;
  localparam logic [31:0] VAL_SIG_CFG = 32'h2406_7fa6;
  localparam logic [31:0] VAL_EXTRA = 32'h0073_1200;
  localparam logic [31:0] VAL_EXT_OPT = 32'h0080_b436;
  localparam logic [87:0] VAL_RAMP = 88'hff_fffe_f7cf_2081_0408_2041;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TX_LEVEL_BIT = 20;
  localparam int THR_LSB = 26;
  localparam int THR_W = 4;
  localparam int MEAS_OFF_BIT = 18;
  localparam int BANK_BIT = 7;

  // ----------------------------------------------------------------
  // Link command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OP_MASK = 8'he0;
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_WRITE = 8'h20;
  localparam logic [7:0] CMD_TOGGLE = 8'h50;
  localparam logic [7:0] TOGGLE_KEY = 8'h53;

  // ----------------------------------------------------------------
  // Controller APB map
  // ----------------------------------------------------------------
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_PART = 8'h08;
  localparam int CTRL_START = 0;
  localparam int CTRL_CARRIER = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_BANK_ERR = 2;
  localparam int ST_BANK = 3;
endpackage : rac_pkg

// ===== rac_spi_if.sv
`timescale 1ns/10ps
// Four-wire serial link between the controller and the register bank
interface rac_spi_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  modport host (output sck, output cs_n, output mosi, input miso);
  modport dev (input sck, input cs_n, input mosi, output miso);
endinterface : rac_spi_if

// ===== rac_tick_div.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Enable divider: one-cycle tick every HALF cycles while running
// ------------------------------------------------------------------
module rac_tick_div #(
  parameter int HALF = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  output logic tick
);
  logic [7:0] cnt;

  // The serial slave needs one cycle to see an edge and one to answer
  if (HALF < 2 || HALF > 255) begin : g_bad_half
    $error("rac_tick_div: HALF must be 2 to 255");
  end

  // Count restarts when idle so the first tick is a full half period away
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end else if (cnt == 8'(HALF - 1)) begin
      cnt <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule : rac_tick_div

// ===== rac_dev.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Auxiliary register bank, serial slave side
// ------------------------------------------------------------------
module rac_dev #(
  parameter logic [31:0] PART_ID = 32'h0000_00a5 // Arbitrary value
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  rac_spi_if.dev LINK,
  input wire logic [rac_pkg::THR_W-1:0] SIGNAL_STRENGTH_CODE,
  output logic TX_HIGH_POWER,
  output logic [rac_pkg::THR_W-1:0] SIGNAL_STRENGTH_THRESHOLD,
  output logic SIGNAL_STRENGTH_MEASURE_ON,
  output logic CARRIER_SENSE,
  output logic BANK_SELECT_STATE
);
  import rac_pkg::*;

  logic sck_q;
  logic [2:0] bit_cnt;
  logic [3:0] byte_idx;
  logic [6:0] shift_in;
  logic [7:0] cmd;
  logic [31:0] out_word;
  logic [79:0] stage;
  logic [31:0] word_mem [0:15];
  logic [87:0] ramp;
  logic bank;

  // ----------------------------------------------------------------
  // Edge and byte decode
  // ----------------------------------------------------------------
  wire rise = LINK.sck & ~sck_q & ~LINK.cs_n;
  wire fall = ~LINK.sck & sck_q & ~LINK.cs_n;
  wire [7:0] rx_byte = {shift_in, LINK.mosi};
  wire byte_end = rise & (bit_cnt == 3'h7);
  wire cmd_end = byte_end & (byte_idx == 4'h0);
  wire data_end = byte_end & (byte_idx != 4'h0);
  wire is_write = (cmd & CMD_OP_MASK) == CMD_WRITE;
  wire [4:0] addr = cmd[4:0];
  wire [4:0] rd_addr = rx_byte[4:0];
  wire rd_cmd = (rx_byte & CMD_OP_MASK) == CMD_READ;
  // Undefined and reserved addresses never change state
  wire word_ok = (addr <= IDX_SIG_CFG) | (addr == IDX_EXTRA) | (addr == IDX_EXT_OPT);
  wire ramp_ok = addr == IDX_RAMP;
  wire [3:0] want = ramp_ok ? RAMP_BYTES : WORD_BYTES;
  wire commit = data_end & is_write & bank & (word_ok | ramp_ok) & (byte_idx == want);
  // Four bits of byte index are needed: ramp frames stage ten bytes
  wire [6:0] stage_pos = {byte_idx - 4'h1, 3'h0};
  wire [31:0] new_word = {rx_byte, stage[23:0]};
  wire [31:0] bank_word = 32'(bank) << BANK_BIT;
  // Only the indicator answers in the primary bank
  wire [31:0] rd_val = !rd_cmd ? RST_WORD : (rd_addr == IDX_BANK) ? bank_word
    : (bank && rd_addr == IDX_PART) ? PART_ID : RST_WORD;

  // ----------------------------------------------------------------
  // Frame position: bits and bytes restart whenever select is high
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RST_N || LINK.cs_n) begin
      bit_cnt <= 3'h0;
      byte_idx <= 4'h0;
      shift_in <= 7'h00;
    end else if (rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      shift_in <= rx_byte[6:0];
      if (bit_cnt == 3'h7 && byte_idx != 4'hf) begin
        byte_idx <= byte_idx + 4'h1;
      end
    end
  end

  // Edge history; select and clock are synchronous to REF_CLK
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= LINK.sck;
    end
  end

  // ----------------------------------------------------------------
  // Command capture and read shifter; data goes out least byte first
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      cmd <= 8'h00;
      out_word <= RST_WORD;
      LINK.miso <= 1'b0;
    end else begin
      if (cmd_end) begin
        cmd <= rx_byte;
        out_word <= rd_val;
      end else if (data_end) begin
        out_word <= out_word >> 8;
      end
      if (LINK.cs_n) begin
        LINK.miso <= 1'b0;
      end else if (fall) begin
        LINK.miso <= (byte_idx != 4'h0) ? out_word[3'h7 - bit_cnt] : 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write staging and commit; short frames leave the register untouched
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      stage <= 80'h0;
    end else if (data_end && byte_idx < RAMP_BYTES) begin
      stage[stage_pos +: 8] <= rx_byte;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < 16; i++) begin
        word_mem[i] <= (5'(i) == IDX_INIT_D) ? RST_INIT_D : RST_WORD;
      end
      ramp <= {RAMP_W{1'b0}};
    end else if (commit && ramp_ok) begin
      ramp <= {rx_byte, stage};
    end else if (commit) begin
      word_mem[addr[3:0]] <= new_word;
    end
  end

  // Bank toggles only on the exact key byte after the toggle command
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      bank <= 1'b0;
    end else if (data_end && byte_idx == 4'h1 && cmd == CMD_TOGGLE
                 && rx_byte == TOGGLE_KEY) begin
      bank <= ~bank;
    end
  end

  // ----------------------------------------------------------------
  // Back-end controls taken from the stored words and the bank flag
  // ----------------------------------------------------------------
  assign TX_HIGH_POWER = word_mem[IDX_TX_LEVEL[3:0]][TX_LEVEL_BIT];
  assign SIGNAL_STRENGTH_THRESHOLD =
    word_mem[IDX_SIG_CFG[3:0]][THR_LSB +: THR_W];
  assign SIGNAL_STRENGTH_MEASURE_ON = ~word_mem[IDX_SIG_CFG[3:0]][MEAS_OFF_BIT];
  assign BANK_SELECT_STATE = bank;

  // Code 0 is the lowest level; a suspended meter never senses a carrier
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      CARRIER_SENSE <= 1'b0;
    end else begin
      CARRIER_SENSE <= SIGNAL_STRENGTH_MEASURE_ON
        & (SIGNAL_STRENGTH_CODE >= SIGNAL_STRENGTH_THRESHOLD);
    end
  end
endmodule : rac_dev

// ===== rac_host.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Bank initialization controller, serial master side
// ------------------------------------------------------------------
module rac_host #(
  parameter int SCK_HALF = 2
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [rac_pkg::WORD_W-1:0] PWDATA,
  output logic [rac_pkg::WORD_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  rac_spi_if.host LINK
);
  import rac_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SETUP = 2'b01,
    S_SHIFT = 2'b11,
    S_GAP = 2'b10
  } rac_state_e;

  typedef enum logic [1:0] {
    K_WRITE,
    K_CHK_AUX,
    K_CHK_PRI,
    K_PART
  } rac_kind_e;

  typedef struct packed {
    rac_kind_e kind;
    logic [7:0] cmd;
    logic [3:0] nbytes;
    logic [87:0] data;
  } rac_step_s;

  localparam logic [3:0] LAST_STEP = 4'hd;
  localparam logic [3:0] WR_BYTES = WORD_BYTES + 4'h1;
  localparam logic [3:0] KEY_BYTES = 4'h2;

  // ----------------------------------------------------------------
  // Init script: enter bank, check, program, read id, leave, check
  // ----------------------------------------------------------------
  function automatic rac_step_s wr(input logic [4:0] idx, input logic [31:0] val);
    rac_step_s s;
    s.kind = K_WRITE;
    s.cmd = CMD_WRITE | {3'h0, idx};
    s.nbytes = WR_BYTES;
    s.data = {56'h0, val};
    return s;
  endfunction : wr

  function automatic rac_step_s rd(input logic [4:0] idx, input rac_kind_e k);
    rac_step_s s;
    s.kind = k;
    s.cmd = CMD_READ | {3'h0, idx};
    s.nbytes = WR_BYTES;
    s.data = 88'h0;
    return s;
  endfunction : rd

  function automatic rac_step_s step_rom(input logic [3:0] n, input logic carrier);
    rac_step_s s;
    s.kind = K_WRITE;
    s.cmd = CMD_TOGGLE;
    s.nbytes = KEY_BYTES;
    s.data = {80'h0, TOGGLE_KEY};
    unique case (n)
      4'h0: s = s;
      4'h1: s = rd(IDX_BANK, K_CHK_AUX);
      4'h2: s = wr(IDX_INIT_A, VAL_INIT_A);
      4'h3: s = wr(IDX_INIT_B, VAL_INIT_B);
      4'h4: s = wr(IDX_INIT_C, VAL_INIT_C);
      4'h5: s = wr(IDX_INIT_D, VAL_INIT_D);
      4'h6: s = wr(IDX_TX_LEVEL, carrier ? VAL_TX_CARRIER : VAL_TX_HIGH);
      4'h7: s = wr(IDX_SIG_CFG, VAL_SIG_CFG);
      4'h8: s = wr(IDX_EXTRA, VAL_EXTRA);
      4'h9: s = wr(IDX_EXT_OPT, VAL_EXT_OPT);
      4'ha: begin
        s = wr(IDX_RAMP, 32'h0);
        s.nbytes = RAMP_BYTES + 4'h1;
        s.data = VAL_RAMP;
      end
      4'hb: s = rd(IDX_PART, K_PART);
      4'hc: s = s;
      4'hd: s = rd(IDX_BANK, K_CHK_PRI);
      default: s = s; // Codes above the last step never run
    endcase
    return s;
  endfunction : step_rom

  rac_state_e state;
  logic [3:0] step;
  logic carrier;
  logic done;
  logic bank_err;
  logic bank_seen;
  logic [31:0] part;
  logic sck;
  logic [2:0] bit_cnt;
  logic [3:0] byte_cnt;
  logic [95:0] buf_sh;
  logic [7:0] rx_byte;
  logic [31:0] rx_word;
  logic tick;

  // ----------------------------------------------------------------
  // APB slave: one wait state, error on unmapped addresses
  // ----------------------------------------------------------------
  wire apb_setup = PSEL & PENABLE & ~PREADY;
  wire apb_done = PSEL & PENABLE & PREADY;
  wire sel_ctrl = PADDR == APB_CTRL;
  wire sel_status = PADDR == APB_STATUS;
  wire sel_part = PADDR == APB_PART;
  wire mapped = sel_ctrl | sel_status | sel_part;
  wire busy = state != S_IDLE;
  // A start while busy is dropped rather than queued
  wire start = apb_done & PWRITE & sel_ctrl & PWDATA[CTRL_START] & ~busy;
  wire [31:0] ctrl_word = 32'(carrier) << CTRL_CARRIER;
  wire [31:0] status_word = (32'(busy) << ST_BUSY) | (32'(done) << ST_DONE)
    | (32'(bank_err) << ST_BANK_ERR) | (32'(bank_seen) << ST_BANK);
  wire [31:0] rd_mux = sel_ctrl ? ctrl_word : sel_status ? status_word
    : sel_part ? part : RST_WORD;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= RST_WORD;
    end else begin
      PREADY <= apb_setup;
      PSLVERR <= apb_setup & ~mapped;
      if (apb_setup) begin
        PRDATA <= PWRITE ? RST_WORD : rd_mux;
      end
    end
  end

  // Mode bit may change at any time; it is sampled per step
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      carrier <= 1'b0;
    end else if (apb_done && PWRITE && sel_ctrl) begin
      carrier <= PWDATA[CTRL_CARRIER];
    end
  end

  // ----------------------------------------------------------------
  // Serial engine: mode 0, msb first in a byte, least byte first
  // ----------------------------------------------------------------
  rac_tick_div #(.HALF(SCK_HALF)) u_div (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .run(busy),
    .tick(tick)
  );

  rac_step_s cur;
  assign cur = step_rom(step, carrier);
  wire last_bit = bit_cnt == 3'h7;
  wire last_byte = byte_cnt == cur.nbytes - 4'h1;
  // Next bit is set up on the falling edge, half a period before use
  wire next_mosi = last_bit ? buf_sh[15] : buf_sh[3'h6 - bit_cnt];
  wire step_bad = (cur.kind == K_CHK_AUX && !rx_word[BANK_BIT])
    || (cur.kind == K_CHK_PRI && rx_word[BANK_BIT]);

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state <= S_IDLE;
      step <= 4'h0;
      sck <= 1'b0;
      LINK.cs_n <= 1'b1;
      LINK.mosi <= 1'b0;
      bit_cnt <= 3'h0;
      byte_cnt <= 4'h0;
      buf_sh <= 96'h0;
      rx_byte <= 8'h00;
      rx_word <= RST_WORD;
    end else if (start) begin
      state <= S_SETUP;
      step <= 4'h0;
    end else if (tick) begin
      unique case (state)
        S_IDLE: state <= S_IDLE;
        S_SETUP: begin
          state <= S_SHIFT;
          LINK.cs_n <= 1'b0;
          buf_sh <= {cur.data, cur.cmd};
          LINK.mosi <= cur.cmd[7];
          bit_cnt <= 3'h0;
          byte_cnt <= 4'h0;
        end
        S_SHIFT: begin
          if (!sck) begin
            sck <= 1'b1;
            rx_byte <= {rx_byte[6:0], LINK.miso};
          end else begin
            sck <= 1'b0;
            bit_cnt <= bit_cnt + 3'h1;
            LINK.mosi <= next_mosi;
            if (last_bit) begin
              buf_sh <= buf_sh >> 8;
              rx_word <= {rx_byte, rx_word[31:8]};
              byte_cnt <= byte_cnt + 4'h1;
            end
            if (last_bit && last_byte) begin
              state <= S_GAP;
              LINK.cs_n <= 1'b1;
              LINK.mosi <= 1'b0;
            end
          end
        end
        S_GAP: begin
          // Script ends on the final check; no other address is touched
          state <= (step == LAST_STEP) ? S_IDLE : S_SETUP;
          step <= (step == LAST_STEP) ? 4'h0 : step + 4'h1;
        end
      endcase
    end
  end

  assign LINK.sck = sck;

  // ----------------------------------------------------------------
  // Results of read steps, gathered when a frame closes
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      done <= 1'b0;
      bank_err <= 1'b0;
      bank_seen <= 1'b0;
      part <= RST_WORD;
    end else if (start) begin
      done <= 1'b0;
      bank_err <= 1'b0;
    end else if (tick && state == S_GAP) begin
      if (cur.kind == K_CHK_AUX || cur.kind == K_CHK_PRI) begin
        bank_seen <= rx_word[BANK_BIT];
      end
      if (step_bad) begin
        bank_err <= 1'b1;
      end
      if (cur.kind == K_PART) begin
        part <= rx_word;
      end
      if (step == LAST_STEP) begin
        done <= 1'b1;
      end
    end
  end
endmodule : rac_host

// ===== rac_link_props.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Link checks beside the serial interface
// ------------------------------------------------------------------
module rac_link_props (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Phases assume the default divider of two cycles per half period
  sequence s_high_half;
    sck [*2] ##1 !sck;
  endsequence
  sequence s_low_half;
    !sck [*2] ##1 (sck || cs_n);
  endsequence
  property p_sck_high;
    $rose(sck) |-> s_high_half;
  endproperty
  property p_sck_low;
    $fell(sck) |-> s_low_half;
  endproperty
  property p_sck_idle;
    cs_n |-> !sck;
  endproperty
  property p_mosi_idle;
    cs_n |-> !mosi;
  endproperty
  // The bank needs a cycle to see the frame end before it lets go
  property p_miso_idle;
    cs_n [*4] |-> !miso;
  endproperty
  property p_mosi_hold;
    sck && $past(sck) |-> $stable(mosi);
  endproperty
  // Select falls with the clock idle and rises on the last falling edge
  property p_cs_on_low;
    $changed(cs_n) |-> !sck && ($past(sck) == cs_n);
  endproperty
  property p_frame_open;
    $fell(cs_n) |-> !sck [*2] ##1 sck;
  endproperty
  property p_gap;
    $rose(cs_n) |-> cs_n [*2];
  endproperty
  property p_frame_len;
    $fell(cs_n) |-> ##[60:420] $rose(cs_n);
  endproperty
  a_sck_high: assert property (p_sck_high) else $error("serial clock high phase length");
  a_sck_low: assert property (p_sck_low) else $error("serial clock low phase length");
  a_sck_idle: assert property (p_sck_idle) else $error("serial clock runs outside frame");
  a_mosi_idle: assert property (p_mosi_idle) else $error("host data not low when idle");
  a_miso_idle: assert property (p_miso_idle) else $error("bank data not low when idle");
  a_mosi_hold: assert property (p_mosi_hold) else $error("host data moved while clock high");
  a_cs_on_low: assert property (p_cs_on_low) else $error("select moved with clock high");
  a_frame_open: assert property (p_frame_open) else $error("first clock edge misplaced");
  a_gap: assert property (p_gap) else $error("gap between frames too short");
  a_frame_len: assert property (p_frame_len) else $error("frame length out of range");
endmodule : rac_link_props

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import rac_pkg::*;
  localparam logic [31:0] DEV_ID = 32'h0000_00c3; // Arbitrary value
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, tx_hi, meas_on, csense, bank, sck_d, csd;
  logic [3:0] code = 4'h0;
  logic [3:0] thr;
  logic [103:0] fsh = 104'h0;
  logic [103:0] fq[$];
  int fn[$];
  int fcnt = 0;
  int error_cnt = 0;
  int n_checks = 0;
  rac_spi_if lnk ();
  rac_host i_rac_host (.REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .LINK(lnk.host));
  rac_dev #(.PART_ID(DEV_ID)) i_rac_dev (.REF_CLK(ref_clk), .RST_N(rst_n), .LINK(lnk.dev),
    .SIGNAL_STRENGTH_CODE(code), .TX_HIGH_POWER(tx_hi), .SIGNAL_STRENGTH_THRESHOLD(thr),
    .SIGNAL_STRENGTH_MEASURE_ON(meas_on), .CARRIER_SENSE(csense), .BANK_SELECT_STATE(bank));
  rac_link_props i_rac_link_props (.REF_CLK(ref_clk), .RST_N(rst_n), .sck(lnk.sck),
    .cs_n(lnk.cs_n), .mosi(lnk.mosi), .miso(lnk.miso));
  // Clock: 40 ns period
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // Frame capture: host bits on each rising serial clock
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    sck_d <= lnk.sck;
    csd <= lnk.cs_n;
    if (!lnk.cs_n && lnk.sck && !sck_d) begin
      fsh <= {fsh[102:0], lnk.mosi};
      fcnt <= fcnt + 1;
    end
    if (lnk.cs_n && !csd) begin
      fq.push_back(fsh);
      fn.push_back(fcnt);
      fsh <= 104'h0;
      fcnt <= 0;
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task results;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task chk(input logic [103:0] seen, input logic [103:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; request held until the ready edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      error_cnt++;
      results;
    end
  endtask : apb
  // Expected frame bits: command, then bytes low first
  function automatic logic [103:0] frm(input logic [7:0] c, input logic [87:0] v, input int n);
    frm = {96'h0, c};
    for (int i = 0; i < n; i++) frm = {frm[95:0], v[8*i +: 8]};
  endfunction : frm
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    logic [31:0] r;
    logic e;
    repeat (2) @(posedge ref_clk);
    chk(tx_hi, 1'b0);
    chk({meas_on, csense}, 2'b11);
    chk(bank, 1'b0);
    apb(1'b0, APB_STATUS, 32'h0, r, e);
    chk(r, 32'h0);
  endtask : t_reset
  // Unmapped places are refused and leave status alone
  task t_unmapped;
    logic [31:0] r;
    logic e;
    apb(1'b0, 8'h0c, 32'h0, r, e);
    chk(e, 1'b1);
    apb(1'b1, 8'h40, 32'hffff_ffff, r, e);
    chk(e, 1'b1);
    apb(1'b0, APB_STATUS, 32'h0, r, e);
    chk({e, r}, 33'h0);
  endtask : t_unmapped
  // Full init script, then the frames and bank outputs are judged
  task t_init(input logic car);
    logic [31:0] r;
    logic e;
    logic [7:0] ec[14];
    logic [87:0] ev[14];
    int en[14];
    int k;
    ec = '{8'h50, 8'h07, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h2c, 8'h2d, 8'h2e,
      8'h08, 8'h50, 8'h07};
    ev = '{88'h53, 88'h0, 88'(VAL_INIT_A), 88'(VAL_INIT_B), 88'(VAL_INIT_C), 88'(VAL_INIT_D),
      88'(car ? VAL_TX_CARRIER : VAL_TX_HIGH), 88'(VAL_SIG_CFG), 88'(VAL_EXTRA),
      88'(VAL_EXT_OPT), VAL_RAMP, 88'h0, 88'h53, 88'h0};
    en = '{1, 0, 4, 4, 4, 4, 4, 4, 4, 4, 11, 0, 1, 0};
    fq.delete();
    fn.delete();
    code <= 4'hf;
    apb(1'b1, APB_CTRL, {30'h0, car, 1'b1}, r, e);
    k = 0;
    do begin
      apb(1'b0, APB_STATUS, 32'h0, r, e);
      k++;
    end while ((r[ST_BUSY] !== 1'b0 || r[ST_DONE] !== 1'b1) && k < 2000);
    if (k >= 2000) begin
      error_cnt++;
      results;
    end
    chk(r, 32'h2);
    apb(1'b0, APB_PART, 32'h0, r, e);
    chk(r, DEV_ID);
    apb(1'b0, APB_CTRL, 32'h0, r, e);
    chk(r, {30'h0, car, 1'b0});
    chk(104'(fq.size()), 104'd14);
    for (k = 0; k < 14 && k < fq.size(); k++) begin
      chk(104'((fq[k] >> (fn[k] - 8)) & 104'hff), 104'(ec[k]));
      if (en[k] > 0) begin
        chk(104'(fn[k]), 104'(8 * (en[k] + 1)));
        chk(fq[k], frm(ec[k], ev[k], en[k]));
      end
    end
    repeat (3) @(posedge ref_clk);
    chk(tx_hi, car ? VAL_TX_CARRIER[TX_LEVEL_BIT] : VAL_TX_HIGH[TX_LEVEL_BIT]);
    chk(thr, VAL_SIG_CFG[THR_LSB +: THR_W]);
    chk({meas_on, csense}, {~VAL_SIG_CFG[MEAS_OFF_BIT], 1'b0});
    chk(bank, 1'b0);
  endtask : t_init
  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_unmapped;
    t_init(1'b0);
    t_init(1'b1);
    results;
  end
endmodule : tb_top
